// *** rtl/tmr8_timer.sv ***
// 8-bit timer/counter with one compare channel behind an AHB-Lite slave
module tmr8_timer (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic external_count_pin,
  input wire logic global_irq_enable,
  input wire logic compare_irq_taken,
  input wire logic overflow_irq_taken,
  output logic compare_output_pin,
  output logic compare_output_override,
  output logic compare_irq_request,
  output logic overflow_irq_request
);

  logic [7:0] control_reg;
  logic [7:0] count_reg;
  logic [7:0] compare_reg;
  logic [7:0] compare_buffer_reg;
  logic [7:0] mask_reg;
  logic [7:0] flags_reg;
  logic count_down_reg;
  logic match_block_reg;
  logic output_reg;
  logic [9:0] prescale_reg;
  logic ext_sync1_reg;
  logic ext_sync2_reg;
  logic ext_prev_reg;
  logic dphase_valid_reg;
  logic dphase_write_reg;
  logic [7:0] dphase_addr_reg;

  logic [1:0] mode;
  logic [1:0] com;
  logic [2:0] clock_select;
  logic count_enable;
  logic wr_control;
  logic wr_count;
  logic wr_compare;
  logic wr_mask;
  logic wr_flags;
  logic [7:0] wdata;
  logic is_pwm;
  logic at_max;
  logic at_bottom;
  logic compare_match;
  logic match_effective;
  logic force_event;
  logic overflow_event;
  logic bottom_event;
  logic top_event;
  logic top_case;
  logic [7:0] count_next;
  logic count_down_next;
  logic output_next;
  logic [1:0] force_com;

  assign mode = {control_reg[tmr8_pkg::TMR8_WGM_HIGH_BIT], control_reg[tmr8_pkg::TMR8_WGM_LOW_BIT]};
  assign com = control_reg[tmr8_pkg::TMR8_COM_HIGH_BIT:tmr8_pkg::TMR8_COM_LOW_BIT];
  assign clock_select = control_reg[tmr8_pkg::TMR8_CS_HIGH_BIT:0];
  assign is_pwm = (mode == tmr8_pkg::TMR8_MODE_PHASE_PWM) || (mode == tmr8_pkg::TMR8_MODE_FAST_PWM);

  // Match action for a given output mode code in non-PWM modes
  function automatic logic match_action(input logic [1:0] code, input logic current);
    logic result;
    result = current;
    unique case (code)
      tmr8_pkg::TMR8_COM_OFF: result = current;
      tmr8_pkg::TMR8_COM_TOGGLE: result = ~current;
      tmr8_pkg::TMR8_COM_CLEAR: result = 1'b0;
      tmr8_pkg::TMR8_COM_SET: result = 1'b1;
    endcase
    return result;
  endfunction

  // AHB-Lite slave: zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dphase_valid_reg <= 1'b0;
      dphase_write_reg <= 1'b0;
      dphase_addr_reg <= tmr8_pkg::TMR8_BYTE_RESET;
    end
    else if (hready)
    begin
      dphase_valid_reg <= hsel && htrans[1];
      dphase_write_reg <= hwrite;
      dphase_addr_reg <= haddr[tmr8_pkg::TMR8_ADDR_BITS-1:0];
    end
  end

  assign wdata = hwdata[7:0];
  assign wr_control = dphase_valid_reg && dphase_write_reg && (dphase_addr_reg == tmr8_pkg::TMR8_CONTROL_OFFSET);
  assign wr_count = dphase_valid_reg && dphase_write_reg && (dphase_addr_reg == tmr8_pkg::TMR8_COUNT_OFFSET);
  assign wr_compare = dphase_valid_reg && dphase_write_reg && (dphase_addr_reg == tmr8_pkg::TMR8_COMPARE_OFFSET);
  assign wr_mask = dphase_valid_reg && dphase_write_reg && (dphase_addr_reg == tmr8_pkg::TMR8_MASK_OFFSET);
  assign wr_flags = dphase_valid_reg && dphase_write_reg && (dphase_addr_reg == tmr8_pkg::TMR8_FLAGS_OFFSET);

  // Read mux on the latched data-phase address so a read right after a write sees the new value
  always_comb
  begin
    hrdata = 32'h0000_0000;
    if (dphase_valid_reg && !dphase_write_reg)
    begin
      unique case (dphase_addr_reg)
        tmr8_pkg::TMR8_CONTROL_OFFSET: hrdata[7:0] = control_reg;
        tmr8_pkg::TMR8_COUNT_OFFSET: hrdata[7:0] = count_reg;
        tmr8_pkg::TMR8_COMPARE_OFFSET: hrdata[7:0] = compare_buffer_reg;
        tmr8_pkg::TMR8_MASK_OFFSET: hrdata[7:0] = mask_reg;
        tmr8_pkg::TMR8_FLAGS_OFFSET: hrdata[7:0] = flags_reg;
        default: hrdata = 32'h0000_0000;
      endcase
    end
  end

  // Control register; the strobe bit is never stored
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      control_reg <= tmr8_pkg::TMR8_BYTE_RESET;
    else if (wr_control)
    begin
      control_reg <= wdata;
      control_reg[tmr8_pkg::TMR8_FORCE_BIT] <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      mask_reg <= tmr8_pkg::TMR8_BYTE_RESET;
    else if (wr_mask)
    begin
      mask_reg <= tmr8_pkg::TMR8_BYTE_RESET;
      mask_reg[tmr8_pkg::TMR8_COMPARE_BIT] <= wdata[tmr8_pkg::TMR8_COMPARE_BIT];
      mask_reg[tmr8_pkg::TMR8_OVERFLOW_BIT] <= wdata[tmr8_pkg::TMR8_OVERFLOW_BIT];
    end
  end

  // Prescaler runs free; a shared divider keeps tick phases aligned across selections
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      prescale_reg <= tmr8_pkg::TMR8_PRESCALE_RESET;
    else
      prescale_reg <= prescale_reg + 10'h001;
  end

  // External pin: two-stage synchroniser, then an edge detector on the second stage
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ext_sync1_reg <= 1'b0;
      ext_sync2_reg <= 1'b0;
      ext_prev_reg <= 1'b0;
    end
    else
    begin
      ext_sync1_reg <= external_count_pin;
      ext_sync2_reg <= ext_sync1_reg;
      ext_prev_reg <= ext_sync2_reg;
    end
  end

  // Count enable is one hclk cycle wide; nothing is clocked by it
  always_comb
  begin
    count_enable = 1'b0;
    unique case (clock_select)
      tmr8_pkg::TMR8_CS_STOP: count_enable = 1'b0;
      tmr8_pkg::TMR8_CS_DIV1: count_enable = 1'b1;
      tmr8_pkg::TMR8_CS_DIV8: count_enable = (prescale_reg & tmr8_pkg::TMR8_DIV8_MASK) == tmr8_pkg::TMR8_DIV8_MASK;
      tmr8_pkg::TMR8_CS_DIV64: count_enable = (prescale_reg & tmr8_pkg::TMR8_DIV64_MASK) == tmr8_pkg::TMR8_DIV64_MASK;
      tmr8_pkg::TMR8_CS_DIV256: count_enable = (prescale_reg & tmr8_pkg::TMR8_DIV256_MASK) == tmr8_pkg::TMR8_DIV256_MASK;
      tmr8_pkg::TMR8_CS_DIV1024: count_enable = prescale_reg == tmr8_pkg::TMR8_DIV1024_MASK;
      tmr8_pkg::TMR8_CS_EXT_FALL: count_enable = ext_prev_reg && !ext_sync2_reg;
      tmr8_pkg::TMR8_CS_EXT_RISE: count_enable = !ext_prev_reg && ext_sync2_reg;
    endcase
  end

  assign at_max = count_reg == tmr8_pkg::TMR8_MAX;
  assign at_bottom = count_reg == tmr8_pkg::TMR8_BOTTOM;
  assign compare_match = count_enable && (count_reg == compare_reg) && !match_block_reg;
  assign top_case = (compare_reg == tmr8_pkg::TMR8_MAX) && com[1];
  assign top_event = count_enable && at_max;
  assign bottom_event = count_enable && at_bottom && count_down_reg;
  assign force_event = wr_control && wdata[tmr8_pkg::TMR8_FORCE_BIT] && !wdata[tmr8_pkg::TMR8_WGM_LOW_BIT];
  assign force_com = wdata[tmr8_pkg::TMR8_COM_HIGH_BIT:tmr8_pkg::TMR8_COM_LOW_BIT];

  // Overflow: at BOTTOM reversal in phase PWM, at MAX otherwise
  assign overflow_event = (mode == tmr8_pkg::TMR8_MODE_PHASE_PWM) ? bottom_event : top_event;

  // Suppressed matches in the PWM special cases
  always_comb
  begin
    match_effective = compare_match;
    if (is_pwm && top_case)
      match_effective = 1'b0;
  end

  // Counter sequence per mode
  always_comb
  begin
    count_next = count_reg;
    count_down_next = count_down_reg;
    if (count_enable)
    begin
      unique case (mode)
        tmr8_pkg::TMR8_MODE_NORMAL, tmr8_pkg::TMR8_MODE_FAST_PWM:
          count_next = count_reg + 8'h01;
        tmr8_pkg::TMR8_MODE_CLEAR_ON_MATCH:
          count_next = (count_reg == compare_reg) ? tmr8_pkg::TMR8_BOTTOM : count_reg + 8'h01;
        tmr8_pkg::TMR8_MODE_PHASE_PWM:
        begin
          if (!count_down_reg && at_max)
          begin
            count_down_next = 1'b1;
            count_next = count_reg - 8'h01;
          end
          else if (count_down_reg && at_bottom)
          begin
            count_down_next = 1'b0;
            count_next = count_reg + 8'h01;
          end
          else if (count_down_reg)
            count_next = count_reg - 8'h01;
          else
            count_next = count_reg + 8'h01;
        end
      endcase
    end
    if (mode != tmr8_pkg::TMR8_MODE_PHASE_PWM)
      count_down_next = 1'b0;
  end

  // Software write to the counter wins over the count in the same cycle
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      count_reg <= tmr8_pkg::TMR8_BYTE_RESET;
      count_down_reg <= 1'b0;
    end
    else
    begin
      count_down_reg <= count_down_next;
      if (wr_count)
        count_reg <= wdata;
      else
        count_reg <= count_next;
    end
  end

  // Block the match on the next count enable after a counter write
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      match_block_reg <= 1'b0;
    else if (wr_count)
      match_block_reg <= 1'b1;
    else if (count_enable)
      match_block_reg <= 1'b0;
  end

  // Compare double buffer; PWM modes update only at TOP (MAX) to avoid glitched pulses
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      compare_buffer_reg <= tmr8_pkg::TMR8_BYTE_RESET;
    else if (wr_compare)
      compare_buffer_reg <= wdata;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      compare_reg <= tmr8_pkg::TMR8_BYTE_RESET;
    else if (!is_pwm)
      compare_reg <= wr_compare ? wdata : compare_buffer_reg;
    else if (top_event)
      compare_reg <= compare_buffer_reg;
  end

  // Waveform output
  always_comb
  begin
    output_next = output_reg;
    unique case (mode)
      tmr8_pkg::TMR8_MODE_NORMAL, tmr8_pkg::TMR8_MODE_CLEAR_ON_MATCH:
        if (match_effective)
          output_next = match_action(com, output_reg);
      tmr8_pkg::TMR8_MODE_FAST_PWM:
      begin
        if (match_effective && com[1])
          output_next = com[0];
        if (top_event && com[1])
          output_next = !com[0];
      end
      tmr8_pkg::TMR8_MODE_PHASE_PWM:
      begin
        if (match_effective && com[1])
          output_next = count_down_reg ? !com[0] : com[0];
        if (top_event && top_case)
          output_next = !com[0];
      end
    endcase
    if (force_event)
      output_next = match_action(force_com, output_reg);
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      output_reg <= 1'b0;
    else
      output_reg <= output_next;
  end

  assign compare_output_pin = output_reg;
  assign compare_output_override = com != tmr8_pkg::TMR8_COM_OFF;

  // Flags: a hardware set in the clearing cycle wins; forced matches never set
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      flags_reg <= tmr8_pkg::TMR8_BYTE_RESET;
    else
    begin
      if (compare_match)
        flags_reg[tmr8_pkg::TMR8_COMPARE_BIT] <= 1'b1;
      else if (compare_irq_taken || (wr_flags && wdata[tmr8_pkg::TMR8_COMPARE_BIT]))
        flags_reg[tmr8_pkg::TMR8_COMPARE_BIT] <= 1'b0;
      if (overflow_event)
        flags_reg[tmr8_pkg::TMR8_OVERFLOW_BIT] <= 1'b1;
      else if (overflow_irq_taken || (wr_flags && wdata[tmr8_pkg::TMR8_OVERFLOW_BIT]))
        flags_reg[tmr8_pkg::TMR8_OVERFLOW_BIT] <= 1'b0;
    end
  end

  assign compare_irq_request = global_irq_enable && mask_reg[tmr8_pkg::TMR8_COMPARE_BIT]
                               && flags_reg[tmr8_pkg::TMR8_COMPARE_BIT];
  assign overflow_irq_request = global_irq_enable && mask_reg[tmr8_pkg::TMR8_OVERFLOW_BIT]
                                && flags_reg[tmr8_pkg::TMR8_OVERFLOW_BIT];

endmodule

// *** rtl/tmr8_pkg.sv ***
// Register map, field layout and encodings for the 8-bit timer/counter
package tmr8_pkg;
  // Register byte offsets on the AHB-Lite slave
  localparam logic [7:0] TMR8_CONTROL_OFFSET = 8'h00;
  localparam logic [7:0] TMR8_COUNT_OFFSET = 8'h04;
  localparam logic [7:0] TMR8_COMPARE_OFFSET = 8'h08;
  localparam logic [7:0] TMR8_MASK_OFFSET = 8'h0c;
  localparam logic [7:0] TMR8_FLAGS_OFFSET = 8'h10;
  localparam int TMR8_ADDR_BITS = 8;

  // Control field positions
  localparam int TMR8_FORCE_BIT = 7;
  localparam int TMR8_WGM_HIGH_BIT = 6;
  localparam int TMR8_COM_HIGH_BIT = 5;
  localparam int TMR8_COM_LOW_BIT = 4;
  localparam int TMR8_WGM_LOW_BIT = 3;
  localparam int TMR8_CS_HIGH_BIT = 2;

  // Mask and flag field positions
  localparam int TMR8_COMPARE_BIT = 7;
  localparam int TMR8_OVERFLOW_BIT = 6;

  // Reset values
  localparam logic [7:0] TMR8_BYTE_RESET = 8'h00;
  localparam logic [9:0] TMR8_PRESCALE_RESET = 10'h000;

  // Counter extremes
  localparam logic [7:0] TMR8_BOTTOM = 8'h00;
  localparam logic [7:0] TMR8_MAX = 8'hff;

  // Prescaler terminal masks: divider minus one
  localparam logic [9:0] TMR8_DIV8_MASK = 10'h007;
  localparam logic [9:0] TMR8_DIV64_MASK = 10'h03f;
  localparam logic [9:0] TMR8_DIV256_MASK = 10'h0ff;
  localparam logic [9:0] TMR8_DIV1024_MASK = 10'h3ff;

  typedef enum logic [1:0] {
    TMR8_MODE_NORMAL = 2'b00,
    TMR8_MODE_PHASE_PWM = 2'b01,
    TMR8_MODE_CLEAR_ON_MATCH = 2'b10,
    TMR8_MODE_FAST_PWM = 2'b11
  } tmr8_mode_type;

  typedef enum logic [2:0] {
    TMR8_CS_STOP = 3'b000,
    TMR8_CS_DIV1 = 3'b001,
    TMR8_CS_DIV8 = 3'b010,
    TMR8_CS_DIV64 = 3'b011,
    TMR8_CS_DIV256 = 3'b100,
    TMR8_CS_DIV1024 = 3'b101,
    TMR8_CS_EXT_FALL = 3'b110,
    TMR8_CS_EXT_RISE = 3'b111
  } tmr8_clock_select_type;

  typedef enum logic [1:0] {
    TMR8_COM_OFF = 2'b00,
    TMR8_COM_TOGGLE = 2'b01,
    TMR8_COM_CLEAR = 2'b10,
    TMR8_COM_SET = 2'b11
  } tmr8_com_type;
endpackage

// *** dv/tmr8_timer_properties.sv ***
// Port-level checks for the 8-bit timer and its bind
module tmr8_timer_properties (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic global_irq_enable,
  input wire logic compare_output_pin,
  input wire logic compare_output_override,
  input wire logic compare_irq_request,
  input wire logic overflow_irq_request
);
  timeunit 1ns;
  timeprecision 1ns;
  logic ap_v;
  logic ap_w;
  logic [7:0] ap_a;
  logic [7:0] ctl_s;
  logic [7:0] msk_s;
  wire ctl_wr = ap_v && ap_w && ap_a == tmr8_pkg::TMR8_CONTROL_OFFSET;
  wire ctl_rd = ap_v && !ap_w && ap_a == tmr8_pkg::TMR8_CONTROL_OFFSET;
  wire msk_hit = ap_v && ap_a == tmr8_pkg::TMR8_MASK_OFFSET;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ap_v <= 1'b0;
      ap_w <= 1'b0;
      ap_a <= 8'h00;
    end
    else if (hready)
    begin
      ap_v <= hsel && htrans[1];
      ap_w <= hwrite;
      ap_a <= haddr[7:0];
    end
  end
  // Shadows let readback be judged without seeing the body
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctl_s <= 8'h00;
      msk_s <= 8'h00;
    end
    else
    begin
      if (ctl_wr)
        ctl_s <= hwdata[7:0];
      if (msk_hit && ap_w)
        msk_s <= hwdata[7:0];
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_reset_quiet: assert property (disable iff (1'b0) !hresetn |->
    !compare_output_pin && !compare_output_override && !compare_irq_request && hrdata == 32'h0)
    else $error("outputs not cleared in reset");
  a_force_reads_zero: assert property (ctl_rd |-> !hrdata[7])
    else $error("force strobe read as one");
  a_ctl_readback: assert property (ctl_rd |-> hrdata[6:0] == ctl_s[6:0])
    else $error("control readback differs");
  a_mask_readback: assert property (msk_hit && !ap_w |-> hrdata == {24'h0, msk_s[7:6], 6'h00})
    else $error("mask readback differs");
  a_override_mode: assert property (compare_output_override == (ctl_s[5:4] != 2'b00))
    else $error("override not tied to output mode");
  a_stopped_holds: assert property (ctl_s[2:0] == 3'b000 && !ctl_wr |=> $stable(compare_output_pin))
    else $error("output moved while stopped");
  a_cmp_req_gate: assert property (compare_irq_request |-> global_irq_enable && msk_s[7])
    else $error("compare request without enables");
  a_ovf_req_gate: assert property (overflow_irq_request |-> global_irq_enable && msk_s[6])
    else $error("overflow request without enables");
endmodule

bind tmr8_timer tmr8_timer_properties u_tmr8_timer_properties (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .global_irq_enable(global_irq_enable), .compare_output_pin(compare_output_pin),
  .compare_output_override(compare_output_override),
  .compare_irq_request(compare_irq_request), .overflow_irq_request(overflow_irq_request)
);

// *** dv/timer8_async_capable_pwm_counter_tb.sv ***
// Self-checking bench for the 8-bit timer over AHB-Lite
module timer8_async_capable_pwm_counter_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] CTL = tmr8_pkg::TMR8_CONTROL_OFFSET;
  localparam logic [7:0] CNT = tmr8_pkg::TMR8_COUNT_OFFSET;
  localparam logic [7:0] CMP = tmr8_pkg::TMR8_COMPARE_OFFSET;
  localparam logic [7:0] MSK = tmr8_pkg::TMR8_MASK_OFFSET;
  localparam logic [7:0] FLG = tmr8_pkg::TMR8_FLAGS_OFFSET;
  logic hclk, hresetn, hsel, hwrite, ext, gie, c_tk, o_tk;
  logic hreadyout, hresp, pin, ovr, c_req, o_req;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  int err_count = 0;
  int samples_checked = 0;
  tmr8_timer u_tmr8_timer (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .external_count_pin(ext), .global_irq_enable(gie),
    .compare_irq_taken(c_tk), .overflow_irq_taken(o_tk), .compare_output_pin(pin),
    .compare_output_override(ovr), .compare_irq_request(c_req), .overflow_irq_request(o_req)
  );
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    xfer(1'b0, a, 8'h00);
    check(rd, {24'h0, e});
  endtask
  task automatic t_reset;
    logic [7:0] offs[6] = '{CTL, CNT, CMP, MSK, FLG, 8'h14};
    foreach (offs[i]) rchk(offs[i], 8'h00);
    check({30'h0, pin, ovr}, 32'h0);
    check({30'h0, hreadyout, hresp}, 32'h2);
    $display("reset test done");
  endtask
  task automatic t_force;
    logic [7:0] c[4] = '{8'ha0, 8'hb0, 8'h90, 8'h90};
    logic e[4] = '{1'b0, 1'b1, 1'b0, 1'b1};
    xfer(1'b1, CNT, 8'h33);
    for (int i = 0; i < 4; i++)
    begin
      xfer(1'b1, CTL, c[i]);
      @(negedge hclk);
      check({30'h0, pin, ovr}, {30'h0, e[i], 1'b1});
    end
    xfer(1'b1, CTL, 8'hd0);
    @(negedge hclk);
    check({31'h0, pin}, 32'h0);
    rchk(CNT, 8'h33);
    rchk(FLG, 8'h00);
    rchk(CTL, 8'h50);
    // Strobe has no effect with a PWM mode written over a non-PWM mode
    xfer(1'b1, CTL, 8'hb8);
    @(negedge hclk);
    check({31'h0, pin}, 32'h0);
    xfer(1'b1, CTL, 8'h50);
    xfer(1'b1, CTL, 8'hf8);
    @(negedge hclk);
    check({31'h0, pin}, 32'h0);
    xfer(1'b1, CTL, 8'h00);
    $display("force test done");
  endtask
  task automatic t_ctc;
    xfer(1'b1, CMP, 8'h05);
    xfer(1'b1, CNT, 8'h00);
    xfer(1'b1, MSK, 8'h80);
    rchk(CMP, 8'h05);
    gie <= 1'b1;
    for (int i = 0; i < 2; i++)
    begin
      xfer(1'b1, CTL, 8'h51);
      repeat (40) @(posedge hclk);
      xfer(1'b1, CTL, 8'h50);
      xfer(1'b0, CNT, 8'h00);
      check({31'h0, rd <= 32'h5}, 32'h1);
      rchk(FLG, 8'h80);
      check({31'h0, c_req}, 32'h1);
      if (i == 0)
      begin
        gie <= 1'b0;
        @(negedge hclk);
        check({31'h0, c_req}, 32'h0);
        @(posedge hclk);
        gie <= 1'b1;
        c_tk <= 1'b1;
        @(posedge hclk);
        c_tk <= 1'b0;
      end
      else
      begin
        xfer(1'b1, FLG, 8'h40);
        rchk(FLG, 8'h80);
        xfer(1'b1, FLG, 8'h80);
      end
      rchk(FLG, 8'h00);
    end
    $display("clear-on-match test done");
  endtask
  task automatic t_ovf;
    xfer(1'b1, CNT, 8'hfd);
    xfer(1'b1, MSK, 8'h40);
    xfer(1'b1, CTL, 8'h01);
    repeat (2) @(posedge hclk);
    xfer(1'b1, CTL, 8'h00);
    rchk(FLG, 8'h40);
    rchk(MSK, 8'h40);
    check({31'h0, o_req}, 32'h1);
    o_tk <= 1'b1;
    @(posedge hclk);
    o_tk <= 1'b0;
    rchk(FLG, 8'h00);
    // Counter written to the compare value: next match must vanish
    xfer(1'b1, CNT, 8'h80);
    xfer(1'b1, CTL, 8'h01);
    xfer(1'b1, CNT, 8'h05);
    xfer(1'b1, CTL, 8'h00);
    rchk(FLG, 8'h00);
    $display("overflow test done");
  endtask
  task automatic t_clk;
    int divs[5] = '{1, 8, 64, 256, 1024};
    int lo;
    for (int i = 0; i < 5; i++)
    begin
      xfer(1'b1, CNT, 8'h00);
      xfer(1'b1, CTL, 8'(i + 1));
      repeat (4 * divs[i]) @(posedge hclk);
      xfer(1'b1, CTL, 8'h00);
      xfer(1'b0, CNT, 8'h00);
      lo = (4 * divs[i] + 3) / divs[i];
      check({31'h0, rd >= 32'(lo) && rd <= 32'(lo + 1)}, 32'h1);
    end
    xfer(1'b1, CNT, 8'h00);
    for (int s = 7; s > 5; s--)
    begin
      xfer(1'b1, CTL, 8'(s));
      repeat (5)
      begin
        repeat (4) @(posedge hclk);
        ext <= 1'b1;
        repeat (4) @(posedge hclk);
        ext <= 1'b0;
      end
    end
    xfer(1'b1, CTL, 8'h00);
    rchk(CNT, 8'h0a);
    $display("clock select test done");
  endtask
  task automatic t_pwm;
    logic [7:0] c[7] = '{8'h69, 8'h69, 8'h69, 8'h79, 8'h39, 8'h29, 8'h29};
    logic [7:0] m[7] = '{8'h40, 8'h80, 8'hff, 8'hff, 8'h40, 8'h40, 8'hff};
    int e[7] = '{130, 258, 512, 0, 382, 128, 510};
    int hi;
    for (int i = 0; i < 7; i++)
    begin
      xfer(1'b1, CMP, m[i]);
      xfer(1'b1, CTL, c[i]);
      // Long settle: buffered compare lands only at TOP
      repeat (1100) @(posedge hclk);
      hi = 0;
      repeat (c[i][6] ? 512 : 510)
      begin
        @(negedge hclk);
        hi += int'(pin === 1'b1);
      end
      check(hi, e[i]);
    end
    xfer(1'b1, CTL, 8'h00);
    $display("pwm test done");
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  initial
  begin
    repeat (40000) @(posedge hclk);
    err_count++;
    report_and_stop();
  end
  initial
  begin
    {hresetn, hsel, hwrite, ext, gie, c_tk, o_tk} = 7'h0;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'b00;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_force();
    t_ctc();
    t_ovf();
    t_clk();
    t_pwm();
    report_and_stop();
  end
endmodule
